// file: src/fwsr_host.sv
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
module fwsr_host (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [17:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);
  typedef enum {ST_IDLE, ST_WSET, ST_WSTRB, ST_RSTRB, ST_RECOV, ST_EVAL} fwsr_state_t;
  fwsr_state_t state_ff;
  logic [17:0] status_valid_address_ff;
  logic [7:0] wdata_ff;
  logic [2:0] op_ff;
  logic [3:0] cnt_ff;
  logic [1:0] nread_ff;
  logic [7:0] rd_a_ff;
  logic [7:0] rd_b_ff;
  logic recheck_ff;
  logic busy_ff;
  logic [1:0] result_ff;
  logic bit3_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic start;
  logic apb_wr;
  logic toggled_ab;

  assign apb_wr = psel && penable && pwrite && !pready_ff;
  assign start = apb_wr && paddr == fwsr_pkg::CTRL_OFS && !busy_ff;
  assign toggled_ab = rd_a_ff[fwsr_pkg::B6] != rd_b_ff[fwsr_pkg::B6];

  // APB slave: one wait state, answer on second access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      if (psel && penable && !pready_ff) begin
        case (paddr)
          fwsr_pkg::CTRL_OFS: prdata_ff <= {29'h0, op_ff};
          fwsr_pkg::ADDR_OFS: prdata_ff <= {14'h0, status_valid_address_ff};
          fwsr_pkg::DATA_OFS: prdata_ff <= {24'h0, wdata_ff};
          fwsr_pkg::STAT_OFS: prdata_ff <= {28'h0, bit3_ff, result_ff, busy_ff};
          fwsr_pkg::RDAT_OFS: prdata_ff <= {24'h0, rd_b_ff};
          default: begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b1;
          end
        endcase
        // Writing control while busy is refused
        if (pwrite && paddr == fwsr_pkg::CTRL_OFS && busy_ff)
          pslverr_ff <= 1'b1;
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // Address and data set-up registers; address doubles as poll address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_valid_address_ff <= 18'h0;
      wdata_ff <= 8'h0;
    end else if (apb_wr && !busy_ff) begin
      if (paddr == fwsr_pkg::ADDR_OFS)
        status_valid_address_ff <= pwdata[17:0];
      if (paddr == fwsr_pkg::DATA_OFS)
        wdata_ff <= pwdata[7:0];
    end
  end

  // Flash bus sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      op_ff <= 3'h0;
      cnt_ff <= 4'h0;
      nread_ff <= 2'h0;
      rd_a_ff <= 8'h0;
      rd_b_ff <= 8'h0;
      recheck_ff <= 1'b0;
      busy_ff <= 1'b0;
      result_ff <= fwsr_pkg::RES_NONE;
      bit3_ff <= 1'b0;
      flash_addr <= 18'h0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_out <= 8'h0;
      flash_dq_oe <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            op_ff <= pwdata[2:0];
            busy_ff <= 1'b1;
            nread_ff <= 2'h0;
            recheck_ff <= 1'b0;
            result_ff <= fwsr_pkg::RES_NONE;
            flash_addr <= status_valid_address_ff;
            cnt_ff <= fwsr_pkg::STROBE_CYC;
            flash_ce_n <= 1'b0;
            if (pwdata[2:0] == fwsr_pkg::OP_WRITE) begin
              flash_dq_out <= wdata_ff;
              flash_dq_oe <= 1'b1;
              state_ff <= ST_WSET;
            end else begin
              flash_oe_n <= 1'b0;
              state_ff <= ST_RSTRB;
            end
          end
        end
        ST_WSET: begin
          flash_we_n <= 1'b0;
          state_ff <= ST_WSTRB;
        end
        ST_WSTRB: begin
          if (cnt_ff == 4'h0) begin
            flash_we_n <= 1'b1;
            cnt_ff <= fwsr_pkg::RECOV_CYC;
            state_ff <= ST_RECOV;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_RSTRB: begin
          if (cnt_ff == 4'h0) begin
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            rd_a_ff <= rd_b_ff;
            rd_b_ff <= flash_dq_in; // Full byte sampled each read
            nread_ff <= (nread_ff == 2'h3) ? 2'h3 : nread_ff + 2'h1;
            cnt_ff <= fwsr_pkg::RECOV_CYC;
            state_ff <= ST_EVAL;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_EVAL: begin
          // Poll decides after at least two reads with recovery between them; other ops after one read
          if (op_ff != fwsr_pkg::OP_POLL || nread_ff == 2'h1) begin
            if (op_ff == fwsr_pkg::OP_BIT3)
              bit3_ff <= rd_b_ff[fwsr_pkg::B3];
            if (op_ff == fwsr_pkg::OP_POLL)
              state_ff <= ST_RECOV;
            else begin
              busy_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end else if (!toggled_ab) begin
            result_ff <= fwsr_pkg::RES_DONE;
            busy_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end else if (recheck_ff) begin
            // Still toggling after bit 5 high: failure, issue reset
            result_ff <= fwsr_pkg::RES_FAIL;
            op_ff <= fwsr_pkg::OP_WRITE;
            flash_dq_out <= fwsr_pkg::RESET_CMD;
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            cnt_ff <= fwsr_pkg::STROBE_CYC;
            state_ff <= ST_WSET;
          end else begin
            // Bit 5 seen high: one more toggle test; bit 7 is not trusted alone
            recheck_ff <= rd_b_ff[fwsr_pkg::B5];
            state_ff <= ST_RECOV;
          end
        end
        ST_RECOV: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          if (cnt_ff == 4'h0) begin
            if (op_ff == fwsr_pkg::OP_POLL) begin
              flash_ce_n <= 1'b0;
              flash_oe_n <= 1'b0;
              cnt_ff <= fwsr_pkg::STROBE_CYC;
              state_ff <= ST_RSTRB;
            end else begin
              busy_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: src/fwsr_pkg.sv
package fwsr_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] RDAT_OFS = 8'h10;
  // Control command codes in bits 2:0 of the control word
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_POLL = 3'h3;
  localparam logic [2:0] OP_BIT3 = 3'h4;
  // Status bit positions in the flash data byte
  localparam int B7 = 7;
  localparam int B6 = 6;
  localparam int B5 = 5;
  localparam int B3 = 3;
  // Reset command byte
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // Bus timing
  localparam int CLK_NS = 8;
  localparam int STROBE_NS = 60;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RECOV_CYC = 4'h3;
  // Poll outcome codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_DONE = 2'h1;
  localparam logic [1:0] RES_FAIL = 2'h2;
endpackage

// file: verification/fwsr_host_properties.sv
`timescale 1ns/100ps
module fwsr_host_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [17:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus timing: one wait state, single-cycle answer
  property p_rdy; $rose(penable) && psel |-> !pready ##1 pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  // Full strobes; data driven only while writing
  property p_wr; $fell(flash_we_n) |-> (!flash_we_n && flash_dq_oe && !flash_ce_n) [*8]; endproperty
  a_wr: assert property (p_wr) else $error("write strobe short");
  property p_rd; $fell(flash_oe_n) |-> (!flash_oe_n && !flash_dq_oe && !flash_ce_n) [*8]; endproperty
  a_rd: assert property (p_rd) else $error("read strobe short");
  property p_excl; flash_oe_n || flash_we_n; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_addr; !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in read");
  // Recovery between cycles
  property p_rec; $rose(flash_we_n) |-> flash_we_n [*4]; endproperty
  a_rec: assert property (p_rec) else $error("write recovery short");
  property p_gap; $rose(flash_oe_n) |-> flash_oe_n [*2]; endproperty
  a_gap: assert property (p_gap) else $error("reads back to back");
  c_wr: cover property ($fell(flash_we_n));
  c_rd: cover property ($fell(flash_oe_n));
  c_err: cover property (pslverr);
endmodule

// file: verification/fwsr_flash_model.sv
`timescale 1ns/100ps
module fwsr_flash_model (
  input wire logic [17:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [7:0] flash_dq_in
);
  logic [7:0] mem [0:15] = '{default: 8'hff};
  logic [7:0] last = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic [7:0] stat;
  int busy_left = 0;
  logic fail = 1'h0;
  logic era = 1'h0;
  logic tog = 1'h0;
  // Status byte while busy; erase shows timer done
  assign stat = {era ? 1'h0 : ~mem[flash_addr[3:0]][7], tog, fail, 1'h0, era, tog & era, 2'h0};
  // Idle bus shows inverse of last byte
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? (busy_left > 0 ? stat : mem[flash_addr[3:0]]) : ~last;
  always @(flash_dq_in) if (!flash_oe_n) last = flash_dq_in;
  // Each status read advances toggle; failure holds busy
  always @(posedge flash_oe_n) if (busy_left > 0) begin
    tog = ~tog;
    if (!fail) busy_left = busy_left - 1;
  end
  // Program only clears bits; reset byte ends status mode
  always @(posedge flash_we_n) if (!flash_ce_n && flash_dq_oe) begin
    last_wr = flash_dq_out;
    if (flash_dq_out == 8'hf0) {busy_left, fail, era} = '0;
    else mem[flash_addr[3:0]] = mem[flash_addr[3:0]] & flash_dq_out;
  end
endmodule

// file: verification/fwsr_host_tb.sv
`timescale 1ns/100ps
module fwsr_host_tb;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, re;
  logic [7:0] paddr, flash_dq_out, flash_dq_in, d;
  logic [31:0] pwdata, prdata, rq, st;
  logic [17:0] flash_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  fwsr_host i_fwsr_host (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
  fwsr_flash_model i_fwsr_flash_model (.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in);
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (n >= 40) n_mismatch++;
    rq = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Poll status until busy drops, bounded
  task automatic wait_idle();
    int n = 0;
    do begin
      apb(1'h0, fwsr_pkg::STAT_OFS, 32'h0);
      n++;
    end while (rq[0] !== 1'h0 && n < 300);
    if (n >= 300) n_mismatch++;
    st = rq;
  endtask
  task automatic op(input logic [2:0] c, input logic [17:0] a, input logic [7:0] wd);
    apb(1'h1, fwsr_pkg::ADDR_OFS, {14'h0, a});
    apb(1'h1, fwsr_pkg::DATA_OFS, {24'h0, wd});
    apb(1'h1, fwsr_pkg::CTRL_OFS, {29'h0, c});
    wait_idle();
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
  initial begin
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h85935d7c));
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    // Program into erased cells, then read back
    // Top bit kept clear so the byte can never be the reset command
    d = 8'($urandom) & 8'h7f;
    op(fwsr_pkg::OP_WRITE, 18'h2, d);
    op(fwsr_pkg::OP_READ, 18'h2, 8'h00);
    apb(1'h0, fwsr_pkg::RDAT_OFS, 32'h0);
    chk(rq, {24'h0, d});
    // Toggle poll, shortest busy run first
    for (int i = 0; i < 4; i++) begin
      i_fwsr_flash_model.busy_left = (i == 0) ? 1 : 2 + ($urandom % 6);
      op(fwsr_pkg::OP_POLL, 18'(i), 8'h00);
      chk(st[2:0], {fwsr_pkg::RES_DONE, 1'h0});
    end
    // Failure ends in fail status and the reset byte
    i_fwsr_flash_model.busy_left = 3;
    i_fwsr_flash_model.fail = 1'h1;
    op(fwsr_pkg::OP_POLL, 18'h1, 8'h00);
    chk(st[2:0], {fwsr_pkg::RES_FAIL, 1'h0});
    chk(i_fwsr_flash_model.last_wr, fwsr_pkg::RESET_CMD);
    // Timer bit in erase, then plain data bit
    i_fwsr_flash_model.era = 1'h1;
    i_fwsr_flash_model.busy_left = 9;
    op(fwsr_pkg::OP_BIT3, 18'h2, 8'h00);
    chk(st[3], 1'h1);
    {i_fwsr_flash_model.busy_left, i_fwsr_flash_model.era} = '0;
    op(fwsr_pkg::OP_BIT3, 18'h2, 8'h00);
    chk(st[3], d[3]);
    // Unmapped read and start while busy are refused
    apb(1'h0, 8'h20, 32'h0);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    i_fwsr_flash_model.busy_left = 12;
    apb(1'h1, fwsr_pkg::CTRL_OFS, 32'h3);
    apb(1'h1, fwsr_pkg::CTRL_OFS, 32'h1);
    chk(re, 1'h1);
    wait_idle();
    chk(st[2:0], {fwsr_pkg::RES_DONE, 1'h0});
    $display("tests done");
    close_out();
  end
endmodule
bind fwsr_host fwsr_host_properties i_fwsr_host_properties (.ref_clk, .rst, .psel, .penable, .pready,
  .pslverr, .flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe);
